// [axis_inputs.sv]
// Purpose: Abort, limit, datum, jog and encoder inputs of one axis; stick calibration registers only
// Assumes: APB slave, zero wait states, inputs from pins
// Notes:   Speeds are rate outputs; a profile generator follows
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "axis_input_params.svh"
module axis_inputs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_in,
  input  wire logic        limit_up_in,
  input  wire logic        limit_down_in,
  input  wire logic        datum_stop_in,
  input  wire logic        datum_approach_in,
  input  wire logic        jog_pos_in,
  input  wire logic        jog_neg_in,
  input  wire logic        jog_fast_in,
  input  wire logic [5:0]  enc_in,
  input  wire logic        motion_step,
  input  wire logic        motion_dir,
  input  wire logic        drive_zero_req,
  output logic             step_out,
  output logic             dir_out,
  output logic             drive_zero,
  output logic             drive_enable,
  output logic             error_out,
  output logic             decel_limit,
  output logic [31:0]      speed_target,
  output logic             jog_step,
  output logic             jog_dir,
  output logic             datum_flag
);
  import axis_input_pkg::*;

  logic [31:0]   ctrl_ff;              // Mode and sense control
  logic [31:0]   limit_decel_rate_ff;  // Deceleration at a limit
  logic [31:0]   slow_jog_speed_ff;    // Slow jog rate
  logic [31:0]   fast_jog_speed_ff;    // Fast jog rate
  logic [3:0]    manual_control_select_ff; // Enabled manual sources
  logic [31:0]   stick_ff [4];         // Centre, range, max, deadband
  logic [31:0]   reply_ff;             // Last command reply
  logic [31:0]   datum_pos_ff;         // Captured datum position
  logic          abort_ff;             // Latched input abort
  logic [8:0]    sync1_ff;             // First synchroniser stage
  logic [8:0]    sync2_ff;             // Second synchroniser stage
  logic [5:0]    esync1_ff;            // Encoder first stage
  logic [5:0]    esync2_ff;            // Encoder second stage
  logic          datum_prev_ff;        // Datum edge history
  jog_state_type jog_ff;               // Jog sequencer
  logic [31:0]   jog_cnt_ff;           // Hold timer
  logic [31:0]   cnt_pos;              // Position count
  logic [31:0]   cnt_aux;              // Auxiliary count
  logic [31:0]   cnt_master;           // Master count
  logic          wr_en;                // APB write strobe
  logic          rd_en;                // APB read strobe
  cmd_type       cmd;                  // Command written this cycle
  logic          stop_open;            // Stop circuit open
  logic          lim_up;               // Upper limit open
  logic          lim_dn;               // Lower limit open
  logic          jog_sw_en;            // Jog switches honoured
  logic          jog_p;                // Jog plus active
  logic          jog_n;                // Jog minus active
  logic          jog_any;              // Either direction active
  logic          blocked;              // Current motion blocked
  logic [31:0]   rdata;                // Read mux
  logic          hit;                  // Address mapped

  // Decode of a register hit, used for writes
  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
    is_reg = (a == off);
  endfunction

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite & ~penable;
  assign cmd   = cmd_type'(pwdata[3:0]);

  // Pin synchronisers, two stages each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff  <= `SYNC_RST;  // Stop and limits start as made: no false abort
      sync2_ff  <= `SYNC_RST;  // Same for the second stage
      esync1_ff <= 6'h00;
      esync2_ff <= 6'h00;
    end else begin
      sync1_ff  <= {stop_in, limit_up_in, limit_down_in, datum_stop_in, datum_approach_in,
                    jog_pos_in, jog_neg_in, jog_fast_in, 1'b0};
      sync2_ff  <= sync1_ff;
      esync1_ff <= enc_in;
      esync2_ff <= esync1_ff;
    end
  end

  // Normally-closed inputs read high when made
  assign stop_open = ~sync2_ff[8];
  assign lim_up    = ~sync2_ff[7];
  assign lim_dn    = ~sync2_ff[6];
  assign jog_sw_en = manual_control_select_ff[`SEL_JOG_SW];
  assign jog_p     = sync2_ff[3] & jog_sw_en;
  assign jog_n     = sync2_ff[2] & jog_sw_en;
  assign jog_any   = jog_p | jog_n;

  // Abort latch: set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_ff <= 1'b0;
    end else if (stop_open) begin
      abort_ff <= 1'b1;
    end else if (wr_en && is_reg(paddr, `OFF_CMD) && cmd == CMD_FAULT_CLEAR) begin
      abort_ff <= 1'b0;
    end
  end

  // Control and settings registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff                  <= `CTRL_RST;
      limit_decel_rate_ff      <= 32'h0000_0000;
      slow_jog_speed_ff        <= 32'h0000_0000;
      fast_jog_speed_ff        <= 32'h0000_0000;
      manual_control_select_ff <= `SEL_RST;
    end else if (wr_en) begin
      if (is_reg(paddr, `OFF_CTRL))        ctrl_ff <= pwdata;
      if (is_reg(paddr, `OFF_LIMIT_DECEL)) limit_decel_rate_ff <= pwdata;
      if (is_reg(paddr, `OFF_SLOW_JOG))    slow_jog_speed_ff <= pwdata;
      if (is_reg(paddr, `OFF_FAST_JOG))    fast_jog_speed_ff <= pwdata;
      if (is_reg(paddr, `OFF_MANUAL_SEL))  manual_control_select_ff <= pwdata[3:0];
    end
  end

  // Stick calibration store
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stick
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stick_ff[gi] <= 32'h0000_0000;
        end else if (wr_en && is_reg(paddr, 12'(`OFF_STICK_CENTRE + 4 * gi))) begin
          stick_ff[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // Command replies with axis address prefix
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_ff <= 32'h0000_0000;
    end else if (wr_en && is_reg(paddr, `OFF_CMD)) begin
      unique case (cmd)
        CMD_MOVE, CMD_HOME_SEARCH: begin
          // Ignored and refused while aborted
          reply_ff <= {`AXIS_ADDR, 20'h00000, abort_ff ? `REPLY_ABORT : `REPLY_OK};
        end
        CMD_ACTIVITY_QUERY: begin
          // Current operation report
          reply_ff <= {`AXIS_ADDR, 20'h00000,
                       abort_ff ? `REPLY_ACT_ABORT : (jog_ff != JOG_IDLE ? `REPLY_ACT_MOVE : `REPLY_ACT_IDLE)};
        end
        default: begin
          reply_ff <= {`AXIS_ADDR, 20'h00000, `REPLY_OK};
        end
      endcase
    end
  end

  // Jog sequencer: single step, hold, slow and fast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jog_ff     <= JOG_IDLE;
      jog_cnt_ff <= 32'h0000_0000;
      jog_step   <= 1'b0;
      jog_dir    <= 1'b0;
    end else begin
      jog_step <= 1'b0;
      unique case (jog_ff)
        JOG_IDLE: begin
          if (jog_any && !abort_ff) begin
            jog_ff     <= JOG_WAIT;
            jog_dir    <= jog_p;
            jog_step   <= 1'b1;
            jog_cnt_ff <= 32'h0000_0000;
          end
        end
        JOG_WAIT: begin
          if (!jog_any) begin
            jog_ff <= JOG_IDLE;
          end else if (jog_cnt_ff >= 32'(`JOG_HOLD_CYCLES)) begin
            jog_ff <= JOG_SLOW;
          end else begin
            jog_cnt_ff <= jog_cnt_ff + 32'h0000_0001;
          end
        end
        JOG_SLOW: begin
          if (!jog_any || abort_ff) jog_ff <= JOG_IDLE;
          else if (sync2_ff[1])     jog_ff <= JOG_FAST;
        end
        JOG_FAST: begin
          if (!jog_any || abort_ff) jog_ff <= JOG_IDLE;
          else if (!sync2_ff[1])    jog_ff <= JOG_SLOW;
        end
      endcase
    end
  end

  // Motion blocked by a limit in its own direction
  assign blocked = (motion_dir & lim_up) | (~motion_dir & lim_dn);

  // Drive outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_out     <= 1'b0;
      dir_out      <= 1'b0;
      drive_zero   <= 1'b1;
      error_out    <= 1'b0;
      drive_enable <= 1'b0;
      decel_limit  <= 1'b0;
      speed_target <= 32'h0000_0000;
    end else begin
      step_out    <= motion_step & ~abort_ff & ~blocked & ctrl_ff[`CTRL_STEPPER];
      dir_out     <= motion_dir & ~abort_ff & ctrl_ff[`CTRL_STEPPER];
      drive_zero  <= drive_zero_req | (abort_ff & ~ctrl_ff[`CTRL_STEPPER]);
      error_out   <= abort_ff;
      // Enable dropped on error unless policy holds it
      drive_enable <= ~abort_ff | ctrl_ff[`CTRL_HALT_POLICY];
      decel_limit <= blocked;
      if (blocked)
        speed_target <= limit_decel_rate_ff;
      else if (jog_ff == JOG_FAST)
        speed_target <= fast_jog_speed_ff;
      else if (jog_ff == JOG_SLOW)
        speed_target <= slow_jog_speed_ff;
      else if (datum_approach_q())
        speed_target <= slow_jog_speed_ff;
      else
        speed_target <= 32'h0000_0000;
    end
  end

  // Approach input slows the home search
  function automatic logic datum_approach_q();
    datum_approach_q = sync2_ff[4];
  endfunction

  // Datum capture on rising datum input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      datum_prev_ff <= 1'b0;
      datum_pos_ff  <= 32'h0000_0000;
      datum_flag    <= 1'b0;
    end else begin
      datum_prev_ff <= sync2_ff[5];
      if (sync2_ff[5] && !datum_prev_ff) begin
        datum_pos_ff <= cnt_pos;
        datum_flag   <= 1'b1;
      end
    end
  end

  // Encoder decoders
  quad_counter u_enc_pos (
    .pclk     (pclk),
    .presetn  (presetn),
    .phase_a  (esync2_ff[0]),
    .phase_b  (esync2_ff[1]),
    .reverse  (ctrl_ff[`CTRL_FB_NEG]),
    .count_ff (cnt_pos)
  );
  quad_counter u_enc_aux (
    .pclk     (pclk),
    .presetn  (presetn),
    .phase_a  (esync2_ff[2]),
    .phase_b  (esync2_ff[3]),
    .reverse  (1'b0),
    .count_ff (cnt_aux)
  );
  quad_counter u_enc_master (
    .pclk     (pclk),
    .presetn  (presetn),
    .phase_a  (esync2_ff[4]),
    .phase_b  (esync2_ff[5]),
    .reverse  (ctrl_ff[`CTRL_FOLLOW_NEG]),
    .count_ff (cnt_master)
  );

  // Read mux
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `OFF_CTRL:         rdata = ctrl_ff;
      `OFF_STATUS:       rdata = {25'h0, datum_flag, jog_ff != JOG_IDLE, lim_dn, lim_up, error_out,
                                  drive_enable, abort_ff};
      `OFF_CMD:          rdata = 32'h0000_0000;
      `OFF_REPLY:        rdata = reply_ff;
      `OFF_LIMIT_DECEL:  rdata = limit_decel_rate_ff;
      `OFF_SLOW_JOG:     rdata = slow_jog_speed_ff;
      `OFF_FAST_JOG:     rdata = fast_jog_speed_ff;
      `OFF_MANUAL_SEL:   rdata = {28'h0, manual_control_select_ff};
      `OFF_STICK_CENTRE: rdata = stick_ff[0];
      `OFF_STICK_RANGE:  rdata = stick_ff[1];
      `OFF_STICK_MAX:    rdata = stick_ff[2];
      `OFF_STICK_DEAD:   rdata = stick_ff[3];
      `OFF_ENC_POS:      rdata = cnt_pos;
      `OFF_ENC_AUX:      rdata = cnt_aux;
      `OFF_ENC_MASTER:   rdata = cnt_master;
      `OFF_DATUM_POS:    rdata = datum_pos_ff;
      `OFF_DEMAND_POS:   rdata = cnt_pos;
      default:           hit = 1'b0;
    endcase
  end

  // APB answer: read data caught in setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd_en) prdata <= rdata;
    end
  end
endmodule

// [axis_input_params.svh]
// Purpose: Constants for the axis input-handling block
// Assumes: APB byte addresses, 32-bit data, pclk at 125 MHz
// Notes:   Definitions only
`ifndef AXIS_INPUT_PARAMS_SVH
`define AXIS_INPUT_PARAMS_SVH
`define CLK_MHZ          125
`define JOG_HOLD_MS      500
`define JOG_HOLD_CYCLES  (`JOG_HOLD_MS * `CLK_MHZ * 1000)
// Register byte offsets
`define OFF_CTRL         12'h000
`define OFF_STATUS       12'h004
`define OFF_CMD          12'h008
`define OFF_REPLY        12'h00C
`define OFF_LIMIT_DECEL  12'h010
`define OFF_SLOW_JOG     12'h014
`define OFF_FAST_JOG     12'h018
`define OFF_MANUAL_SEL   12'h01C
`define OFF_STICK_CENTRE 12'h020
`define OFF_STICK_RANGE  12'h024
`define OFF_STICK_MAX    12'h028
`define OFF_STICK_DEAD   12'h02C
`define OFF_ENC_POS      12'h030
`define OFF_ENC_AUX      12'h034
`define OFF_ENC_MASTER   12'h038
`define OFF_DATUM_POS    12'h03C
`define OFF_DEMAND_POS   12'h040
// Control bits
`define CTRL_STEPPER     0
`define CTRL_HALT_POLICY 1
`define CTRL_FB_NEG      2
`define CTRL_FOLLOW_NEG  3
// Manual select bits
`define SEL_JOG_SW       0
`define SEL_STICK        1
`define SEL_ENC_JOG      2
`define SEL_CHAN_INC     3
// Reset values and axis address prefix
`define CTRL_RST         32'h0000_0000
`define SEL_RST          4'h1
`define AXIS_ADDR        8'h01
`define SYNC_RST         9'h1C0
// Reply codes
`define REPLY_OK         4'h0
`define REPLY_ABORT      4'h1
`define REPLY_ACT_IDLE   4'h2
`define REPLY_ACT_ABORT  4'h3
`define REPLY_ACT_MOVE   4'h4
`endif

// [axis_input_pkg.sv]
// Purpose: Types for the axis input-handling block
// Assumes: Nothing
// Notes:   Constants live in axis_input_params.svh
package axis_input_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_MOVE, CMD_FAULT_CLEAR, CMD_ACTIVITY_QUERY, CMD_HOME_SEARCH
  } cmd_type;
  typedef enum logic [1:0] {JOG_IDLE, JOG_WAIT, JOG_SLOW, JOG_FAST} jog_state_type;
endpackage

// [quad_counter.sv]
// Purpose: Quadrature decoder with signed count
// Assumes: Phases already synchronised to pclk
// Notes:   Illegal double transitions are ignored
`timescale 1ns/100ps
module quad_counter (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        phase_a,   // Synchronised phase A
  input  wire logic        phase_b,   // Synchronised phase B
  input  wire logic        reverse,   // Invert counting sense
  output logic [31:0]      count_ff   // Accumulated count
);
  logic [1:0] prev_ff;                // Previous phase pair
  logic       step;                   // One valid edge
  logic       up;                     // Direction of that edge

  // Gray-order decode of one valid edge
  always_comb begin
    step = (prev_ff[0] ^ phase_a) ^ (prev_ff[1] ^ phase_b);
    up   = (prev_ff[1] ^ phase_a) ^ reverse;
  end

  // Phase history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 2'h0;
    end else begin
      prev_ff <= {phase_b, phase_a};
    end
  end

  // Count by one per valid edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 32'h0000_0000;
    end else if (step) begin
      if (up) begin
        count_ff <= count_ff + 32'h0000_0001;
      end else begin
        count_ff <= count_ff - 32'h0000_0001;
      end
    end
  end
endmodule

// [axis_far_side.sv]
// Purpose: Switch, sensor and encoder model facing the axis pins
// Assumes: Bench calls the tasks just after a rising pclk edge
// Notes:   Closed switch reads high; pins change only after an edge
`timescale 1ns/100ps
module axis_far_side (
  input  wire logic  pclk,
  output logic       stop_in,
  output logic       limit_up_in,
  output logic       limit_down_in,
  output logic       datum_stop_in,
  output logic       datum_approach_in,
  output logic       jog_pos_in,
  output logic       jog_neg_in,
  output logic       jog_fast_in,
  output logic [5:0] enc_in
);
  logic [7:0] sw_ff = 8'h07;  // Stop and limits made at start
  initial enc_in = 6'h00;     // All phases low at time zero
  // Stop and limits are normally closed, open reads low
  assign stop_in           = sw_ff[0];
  assign limit_up_in       = sw_ff[1];
  assign limit_down_in     = sw_ff[2];
  assign datum_stop_in     = sw_ff[3];
  assign datum_approach_in = sw_ff[4];
  // Jog switches are normally open, closed reads high
  assign jog_pos_in        = sw_ff[5];
  assign jog_neg_in        = sw_ff[6];
  assign jog_fast_in       = sw_ff[7];
  // New switch pattern
  task set_pins(input logic [7:0] v);
    sw_ff <= v;
  endtask
  // Gray steps on one channel, phase A leads when moving up
  task enc_step(input int ch, input logic up, input int n);
    logic [1:0] p;
    repeat (n) begin
      @(posedge pclk);
      p = enc_in[2*ch +: 2];
      enc_in[2*ch +: 2] <= up ? {p[0], ~p[1]} : {~p[0], p[1]};
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// [axis_inputs_chk.sv]
// Purpose: Port-level assertions for the axis input block
// Assumes: Halt policy left at its reset value by the bench
// Notes:   Mirrors control and select registers from APB writes
`timescale 1ns/100ps
`include "axis_input_params.svh"
module axis_inputs_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        stop_in,
  input wire logic        limit_up_in,
  input wire logic        jog_pos_in,
  input wire logic        step_out,
  input wire logic        dir_out,
  input wire logic        drive_zero,
  input wire logic        drive_enable,
  input wire logic        error_out,
  input wire logic        jog_step
);
  import axis_input_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] ctrl_ff;  // Control register copy
  logic [3:0] sel_ff;   // Manual select copy
  logic       wr_acc;   // Completed write
  logic       clr_w;    // Fault clear write
  assign wr_acc = psel && penable && pwrite && pready;
  assign clr_w  = wr_acc && paddr == `OFF_CMD && pwdata[3:0] == CMD_FAULT_CLEAR;
  // Track register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 4'h0;
      sel_ff  <= `SEL_RST;
    end else if (wr_acc && paddr == `OFF_CTRL) begin
      ctrl_ff <= pwdata[3:0];
    end else if (wr_acc && paddr == `OFF_MANUAL_SEL) begin
      sel_ff <= pwdata[3:0];
    end
  end
  sequence stop_open_s;
    !stop_in [*3];
  endsequence
  sequence jog_held_s;
    $rose(jog_pos_in) ##1 jog_pos_in [*3];
  endsequence
  abort_latch_a: assert property (stop_open_s |-> ##[1:3] error_out)
    else $error("error output missed an open stop");
  enable_drop_a: assert property (error_out && !ctrl_ff[1] |-> !drive_enable)
    else $error("drive enable on during error");
  step_gate_a: assert property (error_out |-> !step_out && !dir_out)
    else $error("step outputs active during abort");
  zero_force_a: assert property (error_out && !ctrl_ff[0] |-> drive_zero)
    else $error("drive not zeroed during servo abort");
  abort_hold_a: assert property (error_out ##1 !error_out |-> $past(clr_w, 2) || $past(clr_w, 3))
    else $error("abort cleared without fault clear");
  upper_block_a: assert property (!limit_up_in [*5] |-> !(step_out && dir_out))
    else $error("upward step past open limit");
  jog_single_a: assert property ((sel_ff[0] && !error_out) ##0 jog_held_s |-> ##[0:3] jog_step)
    else $error("no single step on jog closure");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
endmodule
bind axis_inputs axis_inputs_chk axis_inputs_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .stop_in(stop_in),
  .limit_up_in(limit_up_in), .jog_pos_in(jog_pos_in), .step_out(step_out), .dir_out(dir_out),
  .drive_zero(drive_zero), .drive_enable(drive_enable), .error_out(error_out), .jog_step(jog_step));

// [testbench.sv]
// Purpose: Self-checking bench for the axis input block
// Assumes: Zero wait APB slave, switch model on the pins
// Notes:   Half second jog hold is too long to reach here
`timescale 1ns/100ps
`include "axis_input_params.svh"
module testbench;
  import axis_input_pkg::*;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, speed_target;
  logic        pready, pslverr, err, seen;
  logic        stop_in, limit_up_in, limit_down_in, datum_stop_in, datum_approach_in;
  logic        jog_pos_in, jog_neg_in, jog_fast_in;
  logic [5:0]  enc_in;
  logic        motion_step = 1'h0, motion_dir = 1'h0, drive_zero_req = 1'h0;
  logic        step_out, dir_out, drive_zero, drive_enable, error_out;
  logic        decel_limit, jog_step, jog_dir, datum_flag;
  int          fail_count = 0, n_checks = 0, cycles = 0;
  always #4 pclk = ~pclk;
  axis_inputs axis_inputs_inst (.*);
  axis_far_side axis_far_side_inst (.*);
  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_checks++;
      if (got !== exp) begin
        fail_count++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Counts, verdict and end of run
  task stop_test;
    begin
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    begin
      apb(1'h0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  // Any jog step pulse within a window
  task watch_jog(input int cyc);
    begin
      seen = 1'h0;
      repeat (cyc) begin
        @(posedge pclk);
        seen = seen | jog_step;
      end
    end
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test;
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (5) @(posedge pclk);
    rd_chk(`OFF_CTRL, `CTRL_RST);
    rd_chk(`OFF_MANUAL_SEL, {28'h0, `SEL_RST});
    rd_chk(`OFF_STATUS, 32'h2);
    apb(1'h0, 12'h044, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    for (int a = 16; a <= 44; a += 4) begin
      if (a != 28) begin
        wr(a[11:0], 32'hA5000000 | a);
        rd_chk(a[11:0], 32'hA5000000 | a);
      end
    end
    $display("test registers done");
    axis_far_side_inst.enc_step(0, 1'h1, 8);
    axis_far_side_inst.enc_step(1, 1'h0, 3);
    axis_far_side_inst.enc_step(2, 1'h1, 5);
    repeat (4) @(posedge pclk);
    rd_chk(`OFF_ENC_POS, 32'h8);
    rd_chk(`OFF_ENC_AUX, 32'hFFFFFFFD);
    rd_chk(`OFF_ENC_MASTER, 32'h5);
    wr(`OFF_CTRL, 32'hC);
    axis_far_side_inst.enc_step(0, 1'h1, 3);
    axis_far_side_inst.enc_step(2, 1'h1, 2);
    repeat (4) @(posedge pclk);
    rd_chk(`OFF_ENC_POS, 32'h5);
    rd_chk(`OFF_ENC_MASTER, 32'h3);
    wr(`OFF_CTRL, 32'h0);
    $display("test encoders done");
    axis_far_side_inst.set_pins(8'hA7);
    watch_jog(12);
    check({31'h0, seen}, 32'h1);
    check({31'h0, jog_dir}, 32'h1);
    check(speed_target, 32'h0);
    axis_far_side_inst.set_pins(8'h07);
    wr(`OFF_MANUAL_SEL, 32'h0);
    axis_far_side_inst.set_pins(8'h47);
    watch_jog(12);
    check({31'h0, seen}, 32'h0);
    axis_far_side_inst.set_pins(8'h07);
    wr(`OFF_MANUAL_SEL, {28'h0, `SEL_RST});
    axis_far_side_inst.set_pins(8'h47);
    watch_jog(12);
    check({30'h0, seen, jog_dir}, 32'h2);
    axis_far_side_inst.set_pins(8'h07);
    repeat (4) @(posedge pclk);
    $display("test jog done");
    axis_far_side_inst.set_pins(8'h0F);
    repeat (6) @(posedge pclk);
    axis_far_side_inst.set_pins(8'h07);
    check({31'h0, datum_flag}, 32'h1);
    apb(1'h0, `OFF_STATUS, 32'h0);
    check({31'h0, rd[6]}, 32'h1);
    rd_chk(`OFF_DATUM_POS, 32'h5);
    axis_far_side_inst.set_pins(8'h17);
    drive_zero_req <= 1'h1;
    repeat (6) @(posedge pclk);
    check(speed_target, 32'hA5000014);
    check({31'h0, drive_zero}, 32'h1);
    axis_far_side_inst.set_pins(8'h07);
    drive_zero_req <= 1'h0;
    repeat (4) @(posedge pclk);
    check(speed_target, 32'h0);
    check({31'h0, drive_zero}, 32'h0);
    $display("test datum done");
    wr(`OFF_CTRL, 32'h1);
    motion_step <= 1'h1;
    motion_dir <= 1'h1;
    repeat (4) @(posedge pclk);
    check({31'h0, step_out}, 32'h1);
    check({31'h0, dir_out}, 32'h1);
    axis_far_side_inst.set_pins(8'h05);
    repeat (6) @(posedge pclk);
    check({31'h0, step_out}, 32'h0);
    check(speed_target, 32'hA5000010);
    apb(1'h0, `OFF_STATUS, 32'h0);
    check({30'h0, rd[4:3]}, 32'h1);
    axis_far_side_inst.set_pins(8'h03);
    motion_dir <= 1'h0;
    repeat (6) @(posedge pclk);
    check({30'h0, step_out, decel_limit}, 32'h1);
    apb(1'h0, `OFF_STATUS, 32'h0);
    check({30'h0, rd[4:3]}, 32'h2);
    axis_far_side_inst.set_pins(8'h07);
    motion_step <= 1'h0;
    wr(`OFF_CTRL, 32'h0);
    $display("test limits done");
    axis_far_side_inst.set_pins(8'h06);
    repeat (6) @(posedge pclk);
    check({31'h0, error_out}, 32'h1);
    check({31'h0, drive_enable}, 32'h0);
    check({31'h0, drive_zero}, 32'h1);
    axis_far_side_inst.set_pins(8'h07);
    wr(`OFF_CMD, {28'h0, CMD_MOVE});
    rd_chk(`OFF_REPLY, {`AXIS_ADDR, 20'h0, `REPLY_ABORT});
    wr(`OFF_CMD, {28'h0, CMD_ACTIVITY_QUERY});
    rd_chk(`OFF_REPLY, {`AXIS_ADDR, 20'h0, `REPLY_ACT_ABORT});
    repeat (10) @(posedge pclk);
    check({31'h0, error_out}, 32'h1);
    wr(`OFF_CMD, {28'h0, CMD_FAULT_CLEAR});
    repeat (4) @(posedge pclk);
    check({31'h0, error_out}, 32'h0);
    check({31'h0, drive_enable}, 32'h1);
    $display("test abort done");
    stop_test;
  end
endmodule
